// >>> logic/npa_pkg.sv
`default_nettype none
package npa_pkg;

  // transfer size as issued by the bus state controller
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_QUAD = 2'b11
  } npa_size_t;

  // width of the external device port
  typedef enum logic {
    PW_16 = 1'b0,
    PW_8  = 1'b1
  } npa_width_t;

  // sequencer states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } npa_state_t;

  // one processor transfer; data is right-justified
  typedef struct packed {
    npa_size_t  size;
    npa_width_t width;
    logic       odd_addr;
    logic       write;
    logic [63:0] data;
  } npa_req_t;

  // one access on the narrow port; a strobe flag stands for write, column and mask of its lane
  typedef struct packed {
    logic [15:0] lane_data;
    logic        write_strobe_lane1;
    logic        write_strobe_lane0;
    logic        write;
    logic        last;
  } npa_beat_t;

  // access counts per size
  localparam logic [3:0] BEATS_16_BYTE = 4'h1;
  localparam logic [3:0] BEATS_16_WORD = 4'h1;
  localparam logic [3:0] BEATS_16_LONG = 4'h2;
  localparam logic [3:0] BEATS_16_QUAD = 4'h4;
  localparam logic [3:0] BEATS_8_BYTE  = 4'h1;
  localparam logic [3:0] BEATS_8_WORD  = 4'h2;
  localparam logic [3:0] BEATS_8_LONG  = 4'h4;
  localparam logic [3:0] BEATS_8_QUAD  = 4'h8;

  // reset values and full buffer count
  localparam logic [2:0] IDX_RST   = 3'h0;
  localparam logic       READY_RST = 1'b1;
  localparam logic [1:0] CNT_RST   = 2'h0;
  localparam logic [1:0] BUF_FULL  = 2'h2;

endpackage
`default_nettype wire

// >>> logic/npa_buf2.sv
`default_nettype none
module npa_buf2
  import npa_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,       // bus clock
  input  wire logic         rst_n,     // synchronised reset, low active
  input  wire logic         in_valid,  // producer has a word
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // head word present (flop)
  input  wire logic         out_ready, // consumer takes head
  output logic [W-1:0]      out_data   // head word (flop)
);

  logic [W-1:0] slot0_q, slot0_d, slot1_q, slot1_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         valid_q, valid_d;
  logic         push, pop;

  // head always lives in slot0 so the outputs come straight from flops
  always_comb begin
    in_ready = (cnt_q != BUF_FULL);
    push     = in_valid && in_ready;
    pop      = valid_q && out_ready;
    slot0_d  = slot0_q;
    slot1_d  = slot1_q;
    cnt_d    = cnt_q;
    if (push && pop) begin
      if (cnt_q == 2'h1) begin
        slot0_d = in_data;
      end else begin
        slot0_d = slot1_q;
        slot1_d = in_data;
      end
    end else if (pop) begin
      slot0_d = slot1_q;
      cnt_d   = cnt_q - 2'h1;
    end else if (push) begin
      if (cnt_q == 2'h0) begin
        slot0_d = in_data;
      end else begin
        slot1_d = in_data;
      end
      cnt_d = cnt_q + 2'h1;
    end
    valid_d = (cnt_d != 2'h0);
  end

  // storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot0_q <= '0;
      slot1_q <= '0;
      cnt_q   <= CNT_RST;
      valid_q <= 1'b0;
    end else begin
      slot0_q <= slot0_d;
      slot1_q <= slot1_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
    end
  end

  assign out_valid = valid_q;
  assign out_data  = slot0_q;

endmodule
`default_nettype wire

// >>> logic/npa_aligner.sv
`default_nettype none
module npa_aligner
  import npa_pkg::*;
(
  input  wire logic      ref_clk,    // 100 MHz bus clock
  input  wire logic      rst_n,      // async reset, low active
  input  wire logic      req_valid,  // transfer offered
  output logic           req_ready,  // idle, transfer taken (flop)
  input  wire npa_req_t  req,        // transfer descriptor
  output logic           beat_valid, // port access present (flop)
  input  wire logic      beat_ready, // device side takes access
  output npa_beat_t      beat        // lane data and strobes (flop)
);

  logic       rst_meta_q, rst_sync_q;
  npa_state_t state_q, state_d;
  npa_req_t   req_q, req_d;
  logic [2:0] idx_q, idx_d;
  logic       ready_q, ready_d;
  logic       buf_in_ready;
  logic       push;
  npa_beat_t  beat_d;

  // access count for a size and port width
  function automatic logic [3:0] beats_of(input npa_size_t sz, input npa_width_t w);
    logic [3:0] n;
    n = BEATS_16_BYTE;
    unique case (sz)
      SZ_BYTE: n = (w == PW_8) ? BEATS_8_BYTE : BEATS_16_BYTE;
      SZ_WORD: n = (w == PW_8) ? BEATS_8_WORD : BEATS_16_WORD;
      SZ_LONG: n = (w == PW_8) ? BEATS_8_LONG : BEATS_16_LONG;
      SZ_QUAD: n = (w == PW_8) ? BEATS_8_QUAD : BEATS_16_QUAD;
    endcase
    return n;
  endfunction

  // lane data and strobes of access idx, most significant part first
  function automatic npa_beat_t beat_of(input npa_req_t r, input logic [2:0] idx);
    npa_beat_t  b;
    logic [3:0] n;
    logic [2:0] rem;
    b   = '0;
    n   = beats_of(r.size, r.width);
    rem = 3'(n - 4'h1 - {1'b0, idx});
    b.write = r.write;
    b.last  = ({1'b0, idx} == (n - 4'h1));
    if (r.width == PW_8) begin
      b.lane_data          = {8'h00, r.data[{rem, 3'b000} +: 8]};
      b.write_strobe_lane0 = 1'b1;
    end else if (r.size == SZ_BYTE) begin
      if (r.odd_addr) begin
        b.lane_data          = {8'h00, r.data[7:0]};
        b.write_strobe_lane0 = 1'b1;
      end else begin
        b.lane_data          = {r.data[7:0], 8'h00};
        b.write_strobe_lane1 = 1'b1;
      end
    end else begin
      b.lane_data          = r.data[{rem[1:0], 4'h0} +: 16];
      b.write_strobe_lane1 = 1'b1;
      b.write_strobe_lane0 = 1'b1;
    end
    return b;
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // sequencer: take a transfer, then emit its accesses one per free buffer slot
  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    idx_d   = idx_q;
    ready_d = ready_q;
    beat_d  = beat_of(req_q, idx_q);
    push    = (state_q == ST_RUN) && buf_in_ready;
    unique case (state_q)
      ST_IDLE: begin
        if (req_valid && ready_q) begin
          req_d   = req;
          idx_d   = IDX_RST;
          ready_d = 1'b0;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // a full buffer stalls here, so no access is ever dropped
        if (push) begin
          if (beat_d.last) begin
            state_d = ST_IDLE;
            ready_d = 1'b1;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
      idx_q   <= IDX_RST;
      ready_q <= READY_RST;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      idx_q   <= idx_d;
      ready_q <= ready_d;
    end
  end

  assign req_ready = ready_q;

  // two-entry buffer decouples a stalling device port from the sequencer
  npa_buf2 #(
    .W ($bits(npa_beat_t))
  ) u_buf (
    .clk       (ref_clk),
    .rst_n     (rst_sync_q),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (beat_d),
    .out_valid (beat_valid),
    .out_ready (beat_ready),
    .out_data  (beat)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_q);

  wire p16 = push && (req_q.width == PW_16);
  wire p8  = push && (req_q.width == PW_8);

  word_lanes16_a: assert property (p16 && req_q.size == SZ_WORD |->
      beat_d.lane_data == req_q.data[15:0] && beat_d.write_strobe_lane1 && beat_d.write_strobe_lane0
      && beat_d.last) else $error("16-bit word lanes wrong");
  even_byte_a: assert property (p16 && req_q.size == SZ_BYTE && !req_q.odd_addr |->
      beat_d.lane_data == {req_q.data[7:0], 8'h00} && beat_d.write_strobe_lane1
      && !beat_d.write_strobe_lane0) else $error("even byte on wrong lane");
  odd_byte_a: assert property (p16 && req_q.size == SZ_BYTE && req_q.odd_addr |->
      beat_d.lane_data == {8'h00, req_q.data[7:0]} && !beat_d.write_strobe_lane1
      && beat_d.write_strobe_lane0) else $error("odd byte on wrong lane");
  long_split16_a: assert property (p16 && req_q.size == SZ_LONG && idx_q == 3'h0 |->
      beat_d.lane_data == req_q.data[31:16] && !beat_d.last
      ##[1:300] (push && beat_d.lane_data == req_q.data[15:0] && beat_d.last))
      else $error("16-bit longword split wrong");
  quad_split16_a: assert property (p16 && req_q.size == SZ_QUAD |->
      (idx_q != 3'h0 || beat_d.lane_data == req_q.data[63:48])
      && (idx_q != 3'h3 || (beat_d.lane_data == req_q.data[15:0] && beat_d.last))
      && beat_d.write_strobe_lane1 && beat_d.write_strobe_lane0) else $error("16-bit quadword wrong");
  lane0_only8_a: assert property (p8 |-> beat_d.write_strobe_lane0 && !beat_d.write_strobe_lane1
      && beat_d.lane_data[15:8] == 8'h00) else $error("8-bit port used upper lane");
  // counts written out per size so a wrong entry in the count function still trips this
  count8_a: assert property (p8 && beat_d.last |->
      (req_q.size == SZ_BYTE && idx_q == 3'h0) || (req_q.size == SZ_WORD && idx_q == 3'h1)
      || (req_q.size == SZ_LONG && idx_q == 3'h3) || (req_q.size == SZ_QUAD && idx_q == 3'h7))
      else $error("8-bit access count wrong");
  word_first8_a: assert property (p8 && req_q.size == SZ_WORD && idx_q == 3'h0 |->
      beat_d.lane_data[7:0] == req_q.data[15:8]) else $error("8-bit word not high byte first");
  quad_first8_a: assert property (p8 && req_q.size == SZ_QUAD && idx_q == 3'h0 |->
      beat_d.lane_data[7:0] == req_q.data[63:56]) else $error("8-bit quadword first byte wrong");
  quad_last8_a: assert property (p8 && req_q.size == SZ_QUAD && idx_q == 3'h7 |->
      beat_d.lane_data[7:0] == req_q.data[7:0] && beat_d.last) else $error("8-bit quadword last byte wrong");
  unused_lane_a: assert property (beat_valid |->
      (beat.write_strobe_lane1 || beat.lane_data[15:8] == 8'h00)
      && (beat.write_strobe_lane0 || beat.lane_data[7:0] == 8'h00)) else $error("unused lane not quiet");
  no_loss_a: assert property (beat_valid && !beat_ready |=> beat_valid && $stable(beat))
      else $error("stalled access changed");

  quad8_done_c: cover property (p8 && req_q.size == SZ_QUAD && beat_d.last);
  long16_done_c: cover property (p16 && req_q.size == SZ_LONG && beat_d.last);
  odd_byte_c: cover property (p16 && req_q.size == SZ_BYTE && req_q.odd_addr);
  stall_full_c: cover property (beat_valid && !beat_ready && state_q == ST_RUN && !buf_in_ready);

endmodule
`default_nettype wire

// >>> sim/npa_dev_model.sv
`default_nettype none
// narrow-port device: takes accesses promptly or with long stalls
module npa_dev_model
  import npa_pkg::*;
(
  input  wire logic      ref_clk,    // bus clock
  input  wire logic      rst_n,      // async reset, low active
  input  wire logic      slow,       // stall three cycles of four
  input  wire logic      beat_valid, // access offered
  input  wire npa_beat_t beat,       // lanes and strobes, unstrobed lanes ignored
  output logic           beat_ready  // access taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;

  // ready pattern; unstrobed lane data is never looked at
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 2'h0;
      beat_ready <= 1'b0;
    end else begin
      // stall pattern only advances while an access is offered
      if (beat_valid) begin
        cnt_q <= cnt_q + 2'h1;
      end
      beat_ready <= #1 (!slow || cnt_q == 2'h3);
    end
  end
endmodule
`default_nettype wire

// >>> sim/narrow_port_big_endian_aligner_tb.sv
`default_nettype none
module narrow_port_big_endian_aligner_tb
  import npa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic      ref_clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      req_valid = 1'b0;
  logic      slow = 1'b0;
  npa_req_t  req = '0;
  logic      req_ready;
  logic      beat_valid;
  logic      beat_ready;
  npa_beat_t beat;
  npa_beat_t got_q[$];
  int        errors = 0;
  int        compares = 0;

  always #5 ref_clk = ~ref_clk;

  npa_aligner dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
                     .req(req), .beat_valid(beat_valid), .beat_ready(beat_ready), .beat(beat));
  npa_dev_model dev_u (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .beat_valid(beat_valid),
                       .beat(beat), .beat_ready(beat_ready));

  // every access the device takes
  always @(posedge ref_clk) if (beat_valid && beat_ready) got_q.push_back(beat);

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one transfer, expected accesses worked out from size and port width
  task automatic run_xfer(npa_size_t sz, npa_width_t w, logic odd, logic wr, logic [63:0] d);
    int n;
    int i;
    logic [15:0] lane;
    logic [1:0] stb;
    n = (w == PW_8) ? (1 << int'(sz)) : (sz == SZ_QUAD ? 4 : (sz == SZ_LONG ? 2 : 1));
    got_q.delete();
    req <= '{size: sz, width: w, odd_addr: odd, write: wr, data: d};
    req_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 50);
    #1 req_valid <= 1'b0;
    // wait for all accesses and for idle again; two spare cycles expose extra beats
    while ((got_q.size() < n || req_ready !== 1'b1) && i < 300) begin
      @(posedge ref_clk);
      #1 i++;
    end
    repeat (2) @(posedge ref_clk);
    #1;
    if (i >= 300) begin
      errors++;
      tally_and_finish();
    end
    chk("access count", 16'(n), 16'(got_q.size()));
    for (int k = 0; k < n && k < got_q.size(); k++) begin
      if (w == PW_8) begin
        lane = {8'h00, 8'(d >> (8 * (n - 1 - k)))};
        stb  = 2'b01;
      end else if (sz == SZ_BYTE) begin
        lane = odd ? {8'h00, d[7:0]} : {d[7:0], 8'h00};
        stb  = odd ? 2'b01 : 2'b10;
      end else begin
        lane = 16'(d >> (16 * (n - 1 - k)));
        stb  = 2'b11;
      end
      chk("lane_data", lane, got_q[k].lane_data);
      chk("strobes", {14'h0, stb}, {14'h0, got_q[k].write_strobe_lane1, got_q[k].write_strobe_lane0});
      chk("last", {15'h0, k == n - 1}, {15'h0, got_q[k].last});
      chk("write", {15'h0, wr}, {15'h0, got_q[k].write});
    end
  endtask

  task automatic t_lanes16();
    run_xfer(SZ_BYTE, PW_16, 1'b0, 1'b1, 64'h5a);
    run_xfer(SZ_BYTE, PW_16, 1'b1, 1'b1, 64'ha5);
    run_xfer(SZ_WORD, PW_16, 1'b0, 1'b0, 64'hc3e1);
  endtask

  task automatic t_long16();
    run_xfer(SZ_LONG, PW_16, 1'b0, 1'b1, 64'h1234_5678);
  endtask

  // slow device fills the two-entry buffer and holds the sequencer back
  task automatic t_quad16_stall();
    slow = 1'b1;
    run_xfer(SZ_QUAD, PW_16, 1'b0, 1'b1, 64'hfedc_ba98_7654_3210);
    slow = 1'b0;
  endtask

  task automatic t_port8();
    for (int s = 0; s < 4; s++) begin
      run_xfer(npa_size_t'(s), PW_8, 1'b1, 1'b1, 64'h0123_4567_89ab_cdef);
    end
    slow = 1'b1;
    run_xfer(SZ_QUAD, PW_8, 1'b0, 1'b0, 64'h8877_6655_4433_2211);
    slow = 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    t_lanes16();
    t_long16();
    t_quad16_stall();
    t_port8();
    tally_and_finish();
  end
endmodule
`default_nettype wire
